// File: hdl/sync_select.sv
// sync source selection register bank with mixer shadow/active copy
// assumes align, strobe and frame inputs are one-cycle pulses synchronous to clk
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module sync_select
   import sync_select_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // sync sources
   input  wire logic        align_in,
   input  wire logic        reference_strobe_input,
   input  wire logic        frame_in,
   // mixer double buffer
   input  wire logic [31:0] mixer_wdata,
   input  wire logic        mixer_we,
   output logic      [31:0] mixer_active,
   // target sync pulses
   output logic             mixer_load,
   output logic             phase_sync,
   output logic             formatter_sync,
   output logic             fifo_in_sync,
   output logic             fifo_out_sync,
   output logic             clkdiv_sync
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic        rst_meta_q;
   logic        rst_n_q;

   // two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // any enabled source fires
   function automatic logic mask_hit(input logic [3:0] mask, input sync_src_type src);
      mask_hit = |(mask & src);
   endfunction : mask_hit

   // register read mux
   function automatic logic [15:0] reg_read(input logic [7:0] idx,
                                            input logic [15:0] ra,
                                            input logic [15:0] rb);
      case (idx)
         IDX_MIX_NCO_FMT: reg_read = ra;
         IDX_FIFO_DIV:    reg_read = rb;
         IDX_FACTORY_A:   reg_read = RST_FACTORY_A;
         IDX_FACTORY_B:   reg_read = RST_FACTORY_B;
         default:         reg_read = 16'h0000;
      endcase
   endfunction : reg_read

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   ahb_req_type req_q;
   ahb_req_type req_d;
   logic [15:0] reg_a_q;
   logic [15:0] reg_a_d;
   logic [15:0] reg_b_q;
   logic [15:0] reg_b_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        hreadyout_q;
   logic        hresp_q;
   wire         addr_take;
   wire         wr_a;
   wire         wr_b;

   // address phase accepted on word-aligned index
   assign addr_take   = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign req_d.valid = addr_take;
   assign req_d.write = hwrite;
   assign req_d.index = haddr[9:2];

   // data phase writes; reserved fields hold their defaults
   assign wr_a    = req_q.valid && req_q.write && (req_q.index == IDX_MIX_NCO_FMT);
   assign wr_b    = req_q.valid && req_q.write && (req_q.index == IDX_FIFO_DIV);
   assign reg_a_d = wr_a ? ((hwdata[15:0] & WMASK_MIX_NCO_FMT) | (RST_MIX_NCO_FMT & ~WMASK_MIX_NCO_FMT))
                         : reg_a_q; // RULE9 RULE5
   assign reg_b_d = wr_b ? ((hwdata[15:0] & WMASK_FIFO_DIV) | (RST_FIFO_DIV & ~WMASK_FIFO_DIV))
                         : reg_b_q; // RULE9 RULE6

   // read data from next-state values so a write just before is seen
   assign hrdata_d = (addr_take && !hwrite) ? {16'h0000, reg_read(haddr[9:2], reg_a_d, reg_b_d)}
                                            : 32'h0000_0000; // RULE9

   // bus state and registers
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         req_q       <= '0;
         reg_a_q     <= RST_MIX_NCO_FMT;
         reg_b_q     <= RST_FIFO_DIV;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
         hresp_q     <= HRESP_OKAY;
      end else begin
         req_q       <= req_d;
         reg_a_q     <= reg_a_d;
         reg_b_q     <= reg_b_d;
         hrdata_q    <= hrdata_d;
         hreadyout_q <= 1'b1;
         hresp_q     <= HRESP_OKAY;
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   wire [3:0] mixer_mask   = reg_a_q[POS_MIXER_SEL +: 4];
   wire [3:0] phase_mask   = reg_a_q[POS_PHASE_SEL +: 4];
   wire [1:0] fmt_sel      = reg_a_q[POS_FMT_SEL +: 2];
   wire       sw_sync      = reg_a_q[POS_SW_SYNC];
   wire [3:0] fifoin_mask  = reg_b_q[POS_FIFOIN_SEL +: 4];
   wire [3:0] fifoout_mask = reg_b_q[POS_FIFOOUT_SEL +: 4];
   wire       div_sel      = reg_b_q[POS_DIV_SEL];

   // ------------------------------------------------------------
   // source vectors per target
   // ------------------------------------------------------------
   logic        auto_q;
   sync_src_type mixer_src;
   sync_src_type phase_src;
   sync_src_type fifoin_src;
   sync_src_type fifoout_src;

   // sources in each target's own bit order
   assign mixer_src   = '{s3: sw_sync, s2: align_in, s1: reference_strobe_input, s0: auto_q}; // RULE1
   assign phase_src   = '{s3: sw_sync, s2: align_in, s1: reference_strobe_input, s0: frame_in}; // RULE3
   assign fifoin_src  = '{s3: sw_sync, s2: 1'b0, s1: frame_in, s0: align_in}; // RULE6
   assign fifoout_src = '{s3: sw_sync, s2: reference_strobe_input, s1: frame_in, s0: align_in}; // RULE7

   // trigger decode
   wire mixer_hit   = mask_hit(mixer_mask, mixer_src); // RULE2
   wire phase_hit   = mask_hit(phase_mask, phase_src); // RULE2
   wire fifoin_hit  = mask_hit(fifoin_mask, fifoin_src); // RULE2
   wire fifoout_hit = mask_hit(fifoout_mask, fifoout_src); // RULE2
   wire fmt_hit     = (fmt_sel == FMT_FRAME) ? frame_in :
                      (fmt_sel == FMT_ALIGN) ? align_in : 1'b0; // RULE4
   wire div_hit     = div_sel ? fifoin_hit : reference_strobe_input; // RULE8

   // ------------------------------------------------------------
   // mixer double buffer and target pulses
   // ------------------------------------------------------------
   logic [31:0] shadow_q;
   logic [31:0] shadow_d;
   logic [31:0] active_q;
   logic [31:0] active_d;
   logic        mixer_load_q;
   logic        phase_sync_q;
   logic        formatter_sync_q;
   logic        fifo_in_sync_q;
   logic        fifo_out_sync_q;
   logic        clkdiv_sync_q;

   // shadow takes writes; active copies it only on a mixer sync
   assign shadow_d = mixer_we ? mixer_wdata : shadow_q; // RULE10
   assign active_d = mixer_hit ? shadow_q : active_q; // RULE10 RULE1

   // one-cycle sync pulses, auto-sync one cycle after a shadow write
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         auto_q           <= 1'b0;
         shadow_q         <= 32'h0000_0000;
         active_q         <= 32'h0000_0000;
         mixer_load_q     <= 1'b0;
         phase_sync_q     <= 1'b0;
         formatter_sync_q <= 1'b0;
         fifo_in_sync_q   <= 1'b0;
         fifo_out_sync_q  <= 1'b0;
         clkdiv_sync_q    <= 1'b0;
      end else begin
         auto_q           <= mixer_we;
         shadow_q         <= shadow_d;
         active_q         <= active_d;
         mixer_load_q     <= mixer_hit;
         phase_sync_q     <= phase_hit;
         formatter_sync_q <= fmt_hit;
         fifo_in_sync_q   <= fifoin_hit;
         fifo_out_sync_q  <= fifoout_hit;
         clkdiv_sync_q    <= div_hit;
      end
   end

   assign mixer_active   = active_q;
   assign mixer_load     = mixer_load_q;
   assign phase_sync     = phase_sync_q;
   assign formatter_sync = formatter_sync_q;
   assign fifo_in_sync   = fifo_in_sync_q;
   assign fifo_out_sync  = fifo_out_sync_q;
   assign clkdiv_sync    = clkdiv_sync_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_q);

   AST_MIXER_SRC: assert property ((mixer_mask[2] && align_in) |=> mixer_load) // RULE1
      else $error("mixer load missed an enabled align event");
   AST_MIXER_OFF: assert property ((mixer_mask == 4'h0) |=> !mixer_load) // RULE2
      else $error("mixer load with no source enabled");
   AST_PHASE_FRAME: assert property ((phase_mask[0] && frame_in) |=> phase_sync) // RULE3
      else $error("phase sync missed an enabled frame event");
   AST_FMT_NONE: assert property ((fmt_sel[1]) |=> !formatter_sync) // RULE4
      else $error("formatter synced while disabled");
   AST_FMT_FRAME: assert property ((fmt_sel == FMT_FRAME && frame_in) |=> formatter_sync) // RULE4
      else $error("formatter missed frame");
   AST_SW_HOLD: assert property ((sw_sync && !wr_a) |=> sw_sync) // RULE5
      else $error("software sync cleared itself");
   AST_FIFOIN_ZERO: assert property (fifoin_mask[2] == 1'b0) // RULE6
      else $error("fifo input mask bit 14 not zero");
   AST_FIFOOUT_REF: assert property ((fifoout_mask[2] && reference_strobe_input) |=> fifo_out_sync) // RULE7
      else $error("fifo output missed strobe");
   AST_DIV_REF: assert property ((!div_sel && reference_strobe_input) |=> clkdiv_sync) // RULE8
      else $error("divider missed strobe");
   AST_DIV_FIFO: assert property ((div_sel) |=> (clkdiv_sync == $past(fifoin_hit))) // RULE8
      else $error("divider not following fifo input selection");
   AST_RSVD: assert property (reg_a_q[11:8] == 4'h1 && reg_a_q[0] == 1'b0 && reg_b_q[7:1] == 7'h00) // RULE9
      else $error("reserved field changed");
   AST_ACTIVE_HOLD: assert property ((!mixer_hit) |=> $stable(active_q)) // RULE10
      else $error("active mixer copy changed without sync");
   AST_AUTO: assert property ((mixer_we && mixer_mask[0]) |=> ##1 (mixer_load && active_q == $past(mixer_wdata, 2))) // RULE10
      else $error("auto-sync did not load written value");

   // ------------------------------------------------------------
   // further source and field checks
   // ------------------------------------------------------------
   // strobe path into the mixer group
   AST_MIXER_REF: assert property ((mixer_mask[1] && reference_strobe_input) |=> mixer_load) // RULE1
      else $error("mixer load missed an enabled strobe event");
   // software sync reaches the phase accumulators
   AST_PHASE_SW: assert property ((phase_mask[3] && sw_sync) |=> phase_sync) // RULE3
      else $error("phase sync missed the software sync");
   // no phase pulse with an empty mask
   AST_PHASE_OFF: assert property ((phase_mask == 4'h0) |=> !phase_sync) // RULE2
      else $error("phase sync with no source enabled");
   // formatter on the align pin
   AST_FMT_ALIGN: assert property ((fmt_sel == FMT_ALIGN && align_in) |=> formatter_sync) // RULE4
      else $error("formatter missed align");
   // writing the software bit sets the level
   AST_SW_SET: assert property ((wr_a && hwdata[POS_SW_SYNC]) |=> sw_sync) // RULE5
      else $error("software sync not set by write");
   // frame path into the fifo input side
   AST_FIFOIN_FRAME: assert property ((fifoin_mask[1] && frame_in) |=> fifo_in_sync) // RULE6
      else $error("fifo input missed frame");
   // no fifo output pulse with an empty mask
   AST_FIFOOUT_OFF: assert property ((fifoout_mask == 4'h0) |=> !fifo_out_sync) // RULE7
      else $error("fifo output pulse with no source enabled");
   // factory register reads back its fixed value
   AST_FACTORY_RD: assert property ((addr_take && !hwrite && haddr[9:2] == IDX_FACTORY_B)
                                    |=> (hrdata_q == {16'h0000, RST_FACTORY_B})) // RULE9
      else $error("factory register read wrong value");
   // active copy takes the shadow on a mixer sync
   AST_SHADOW_LOAD: assert property (mixer_hit |=> (active_q == $past(shadow_q))) // RULE10
      else $error("active mixer copy did not take the shadow");

   // main scenarios
   COV_AUTO: cover property (mixer_we ##2 mixer_load);
   COV_SW: cover property (wr_a ##1 sw_sync ##1 phase_sync);
   COV_DIV: cover property (div_sel && clkdiv_sync);
   COV_MULTI: cover property (mixer_mask[2] && mixer_mask[1] && mixer_load);
   COV_FMT_ALIGN: cover property (fmt_sel == FMT_ALIGN && formatter_sync);

endmodule : sync_select

`default_nettype wire

// File: hdl/sync_select_pkg.sv
// Summary of operation
// [RULE1] mixer shadow loads on sources in bits 15:12: sw, align, strobe, write; default 0001
// [RULE2] each mask bit set enables its source; any enabled event triggers the target
// [RULE3] both phase accumulators resync on bits 7:4: sw, align, strobe, frame; default 0100
// [RULE4] formatter uses one source: 00 frame, 01 align, 10 or 11 none; reset 00
// [RULE5] software sync bit is a level until software writes zero; resets to zero
// [RULE6] fifo input side mask 15:12: sw, always zero, frame, align; default 0010
// [RULE7] fifo output side mask 11:8: sw, strobe, frame, align; default 0100
// [RULE8] divider aligns to strobe when select is 0, else to fifo input mask hits
// [RULE9] reserved fields and both factory registers keep their default values
// [RULE10] double-buffered values wait in a shadow copy until an enabled sync fires
//
// constants, field positions and carrier types for the sync source selection block
// assumes a 32-bit AHB-Lite register bus and one 40 MHz clock
package sync_select_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_MIX_NCO_FMT = 8'h1f;
   localparam logic [7:0]  IDX_FIFO_DIV    = 8'h20;
   localparam logic [7:0]  IDX_FACTORY_A   = 8'h21;
   localparam logic [7:0]  IDX_FACTORY_B   = 8'h22;

   // reset values
   localparam logic [15:0] RST_MIX_NCO_FMT = 16'h1140;
   localparam logic [15:0] RST_FIFO_DIV    = 16'h2400;
   localparam logic [15:0] RST_FACTORY_A   = 16'h0000;
   localparam logic [15:0] RST_FACTORY_B   = 16'h1b1b;

   // writable bits; everything else is a fixed reserved field
   localparam logic [15:0] WMASK_MIX_NCO_FMT = 16'hf0fe;
   localparam logic [15:0] WMASK_FIFO_DIV    = 16'hbf01;

   // field positions in the mixer / phase / formatter register
   localparam int          POS_MIXER_SEL  = 12;
   localparam int          POS_PHASE_SEL  = 4;
   localparam int          POS_FMT_SEL    = 2;
   localparam int          POS_SW_SYNC    = 1;
   // field positions in the fifo / divider register
   localparam int          POS_FIFOIN_SEL  = 12;
   localparam int          POS_FIFOOUT_SEL = 8;
   localparam int          POS_DIV_SEL     = 0;

   // formatter source codes
   localparam logic [1:0]  FMT_FRAME = 2'h0;
   localparam logic [1:0]  FMT_ALIGN = 2'h1;

   // ahb encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'b0;

   // sync events of one cycle, in mask bit order msb first
   typedef struct packed {
      logic s3;
      logic s2;
      logic s1;
      logic s0;
   } sync_src_type;

   // ahb address phase captured for the data phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } ahb_req_type;

endpackage : sync_select_pkg

// File: testbench/sync_select_tb_top.sv
// self-checking bench for the sync source selection register bank
// assumes the design package is compiled first and the bench is the only bus master
`timescale 1ns/10ps
`default_nettype none

module sync_select_tb_top;
   import sync_select_pkg::*;

   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        align_in = 1'b0;
   logic        strobe = 1'b0;
   logic        frame_in = 1'b0;
   logic [31:0] mixer_wdata = 32'h0;
   logic        mixer_we = 1'b0;
   logic [31:0] mixer_active;
   logic [5:0]  pulses;
   logic [31:0] rd;
   int          bad_count = 0;
   int          total_checks = 0;

   // 40 mhz clock
   always #12.5 clk = ~clk;

   // ---------------------------------------------
   // design under test
   // ---------------------------------------------
   sync_select dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .align_in(align_in), .reference_strobe_input(strobe), .frame_in(frame_in),
      .mixer_wdata(mixer_wdata), .mixer_we(mixer_we), .mixer_active(mixer_active),
      .mixer_load(pulses[5]), .phase_sync(pulses[4]), .formatter_sync(pulses[3]),
      .fifo_in_sync(pulses[2]), .fifo_out_sync(pulses[1]), .clkdiv_sync(pulses[0]));

   // ---------------------------------------------
   // compare and closing tasks
   // ---------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_sync(input logic [5:0] exp);
      total_checks++;
      if (pulses !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t pulses got=%h exp=%h", $time, pulses, exp);
      end
   endtask : chk_sync

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // ---------------------------------------------
   // bus and source tasks
   // ---------------------------------------------
   // bounded wait for hready sampled high at a rising edge
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         test_done();
      end
   endtask : wait_ready

   // one single ahb transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {16'h0, wd};
      wait_ready();
      rd = hrdata;
      chk_reg({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask : ahb

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      ahb(1'b0, idx, 16'h0);
      chk_reg(rd, exp);
   endtask : rdchk

   // src is {mixer_we, frame, strobe, align}; pulses checked dly edges later
   task automatic fire(input logic [3:0] src, input int dly, input logic [5:0] exp);
      {mixer_we, frame_in, strobe, align_in} <= src;
      @(posedge clk);
      {mixer_we, frame_in, strobe, align_in} <= 4'h0;
      repeat (dly - 1) @(posedge clk);
      #1 chk_sync(exp);
   endtask : fire

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      wait_ready();
      // reset values, unmapped index
      rdchk(IDX_MIX_NCO_FMT, 32'h0000_1140);
      rdchk(IDX_FIFO_DIV, 32'h0000_2400);
      rdchk(IDX_FACTORY_A, 32'h0000_0000);
      rdchk(IDX_FACTORY_B, 32'h0000_1b1b);
      rdchk(8'h23, 32'h0);
      chk_reg(mixer_active, 32'h0);
      // default selections
      fire(4'h1, 1, 6'b010000);
      fire(4'h2, 1, 6'b000011);
      fire(4'h4, 1, 6'b001100);
      mixer_wdata <= 32'ha5a5_5a5a;
      fire(4'h8, 2, 6'b100000);
      chk_reg(mixer_active, 32'ha5a5_5a5a);
      // reserved bits and factory registers hold
      ahb(1'b1, IDX_MIX_NCO_FMT, 16'hffff);
      ahb(1'b1, IDX_FIFO_DIV, 16'hffff);
      ahb(1'b1, IDX_FACTORY_A, 16'hffff);
      ahb(1'b1, IDX_FACTORY_B, 16'h0000);
      rdchk(IDX_MIX_NCO_FMT, 32'h0000_f1fe);
      rdchk(IDX_FIFO_DIV, 32'h0000_bf01);
      rdchk(IDX_FACTORY_A, 32'h0000_0000);
      rdchk(IDX_FACTORY_B, 32'h0000_1b1b);
      // multi-source masks, formatter on align, divider from fifo input mask
      ahb(1'b1, IDX_MIX_NCO_FMT, 16'h6114);
      ahb(1'b1, IDX_FIFO_DIV, 16'h1301);
      fire(4'h1, 1, 6'b101111);
      fire(4'h2, 1, 6'b100000);
      fire(4'h4, 1, 6'b010010);
      // shadow waits for an enabled source
      mixer_wdata <= 32'h1234_abcd;
      fire(4'h8, 2, 6'b000000);
      chk_reg(mixer_active, 32'ha5a5_5a5a);
      fire(4'h1, 1, 6'b101111);
      chk_reg(mixer_active, 32'h1234_abcd);
      // formatter codes that disable it
      for (int c = 2; c < 4; c++) begin
         ahb(1'b1, IDX_MIX_NCO_FMT, 16'h6110 | 16'(c << 2));
         fire(4'h1, 1, 6'b100111);
         fire(4'h4, 1, 6'b010010);
      end
      // software sync is a level until cleared
      ahb(1'b1, IDX_FIFO_DIV, 16'h8801);
      ahb(1'b1, IDX_MIX_NCO_FMT, 16'h8182);
      repeat (2) @(posedge clk);
      #1 chk_sync(6'b110111);
      @(posedge clk);
      #1 chk_sync(6'b110111);
      ahb(1'b1, IDX_MIX_NCO_FMT, 16'h8180);
      repeat (3) @(posedge clk);
      #1 chk_sync(6'b000000);
      test_done();
   end

endmodule : sync_select_tb_top

`default_nettype wire
